// ===== inc/uart_regs_consts.vh
/*
 * register offsets, field positions, page keys and reset values for the
 * per-channel register bank of the four-channel uart.
 * assumes: included by the register bank only; holds definitions alone.
 */
`ifndef UART_REGS_CONSTS_VH
`define UART_REGS_CONSTS_VH

// number of channels and width of the channel select
`define CHAN_COUNT 4
`define CHAN_SEL_W 2

// register addresses within a page
`define ADDR_HOLDING 3'h0
`define ADDR_ENABLE 3'h1
`define ADDR_STATUS_CTRL 3'h2
`define ADDR_LINE_CONTROL 3'h3
`define ADDR_MODEM_CONTROL 3'h4
`define ADDR_LINE_STATUS 3'h5
`define ADDR_MODEM_STATUS 3'h6
`define ADDR_SCRATCH 3'h7

// line control value that opens the enhanced page, and divisor access bit
`define ENHANCED_KEY 8'hbf
`define LC_DIVISOR_BIT 7

// page codes
`define PAGE_BASE 2'h0
`define PAGE_DIVISOR 2'h1
`define PAGE_ENHANCED 2'h2

// enhanced features bit that unlocks the extended bits
`define EF_EXTEND_BIT 4

// fifo control fields
`define FC_ENABLE_BIT 0
`define FC_RX_RESET_BIT 1
`define FC_TX_RESET_BIT 2
`define FC_STORED_MASK 8'hf9

// bits that exist only while the extended bits are unlocked
`define IE_EXT_MASK 8'hf0
`define FC_EXT_MASK 8'h30
`define MC_EXT_MASK 8'he0
`define IS_EXT_MASK 8'h30
`define DF_STORED_MASK 8'h3f

// reset values
`define REG_RESET 8'h00
`define FLOW_CHAR_RESET 8'h00

`endif

// ===== logic/quad_uart_regs.v
/*
 * register bank for four uart channels: address decode over three pages
 * (base, divisor, enhanced), per-channel storage, read mux, fifo ready
 * summary and modem status change flags.
 * assumes: host bus strobes are synchronous to ref_clk and last one cycle
 * per access; receiver, transmitter and interrupt logic live outside and
 * consume the configuration outputs; modem pins are asynchronous.
 */
// Functional notes
// - four channels each own independent register set
// - address 0 base page: receive read, transmit write
// - divisor page: low, high, fraction if unlocked
// - enhanced features at 010 only with key
// - base write 010 is fifo control fields
// - status select low reads fifo ready summary
// - interrupt enable bit layout at address 001
// - extended bits inert and zero unless unlocked
// - base read 010 gives interrupt status
// - line control field layout at address 011
// - modem control field layout at address 100
// - line status read-only at address 101
// - modem status changes and states, read-only
// - scratch byte at 111 has no effect
// - enhanced page 100-111 hold flow characters
// - reset clears all four flow characters
`timescale 1ns/10ps
`include "uart_regs_consts.vh"

module quad_uart_regs (
	input wire ref_clk,
	input wire reset,
	input wire [`CHAN_SEL_W-1:0] chan_sel,
	input wire [2:0] reg_addr,
	input wire rd_strobe,
	input wire wr_strobe,
	input wire [7:0] wr_data,
	input wire fifo_status_select_n,
	input wire [31:0] rx_char_all,
	input wire [31:0] line_status_all,
	input wire [23:0] int_source_all,
	input wire [15:0] modem_pins_n_all,
	input wire [3:0] tx_ready_n,
	input wire [3:0] rx_ready_n,
	output reg [7:0] rd_data,
	output reg [3:0] rx_char_pop,
	output reg [3:0] tx_char_load,
	output reg [7:0] tx_char_data,
	output reg [3:0] rx_fifo_reset,
	output reg [3:0] tx_fifo_reset,
	output reg [31:0] line_control_all,
	output reg [31:0] int_enable_all,
	output reg [31:0] fifo_control_all,
	output reg [31:0] modem_control_all,
	output reg [31:0] enhanced_all,
	output reg [31:0] divisor_low_all,
	output reg [31:0] divisor_high_all,
	output reg [31:0] divisor_frac_all,
	output reg [31:0] resume_char_one_all,
	output reg [31:0] resume_char_two_all,
	output reg [31:0] stop_char_one_all,
	output reg [31:0] stop_char_two_all
);

	// per-channel storage, one word per channel
	reg [7:0] line_control_q [0:`CHAN_COUNT-1];
	reg [7:0] int_enable_q [0:`CHAN_COUNT-1];
	reg [7:0] fifo_control_q [0:`CHAN_COUNT-1];
	reg [7:0] modem_control_q [0:`CHAN_COUNT-1];
	reg [7:0] scratch_q [0:`CHAN_COUNT-1];
	reg [7:0] div_low_q [0:`CHAN_COUNT-1];
	reg [7:0] div_high_q [0:`CHAN_COUNT-1];
	reg [7:0] div_frac_q [0:`CHAN_COUNT-1];
	reg [7:0] enhanced_q [0:`CHAN_COUNT-1];
	reg [7:0] resume_one_q [0:`CHAN_COUNT-1];
	reg [7:0] resume_two_q [0:`CHAN_COUNT-1];
	reg [7:0] stop_one_q [0:`CHAN_COUNT-1];
	reg [7:0] stop_two_q [0:`CHAN_COUNT-1];
	reg [3:0] modem_delta_q [0:`CHAN_COUNT-1];
	// modem pin synchronisers and previous value for change detection
	reg [15:0] modem_meta_q;
	reg [15:0] modem_sync_q;
	reg [15:0] modem_prev_q;

	reg [7:0] rd_d;
	reg [1:0] page;
	reg ext;
	integer i;
	genvar g;

	// unlock bit and pin changes of every channel, read by several processes
	wire [`CHAN_COUNT-1:0] unlocked;
	wire [4*`CHAN_COUNT-1:0] modem_change;
	// side-effect reads: modem status clears flags, holding pops a character
	wire msr_read;
	wire hold_read;
	// modem status byte of the selected channel, shown in two pages
	wire [7:0] msr_value;

	// one copy per channel; the loop keeps the four copies alike
	generate
		for (g = 0; g < `CHAN_COUNT; g = g + 1) begin : chan_taps
			assign unlocked[g] = enhanced_q[g][`EF_EXTEND_BIT];
			assign modem_change[g*4 +: 4] = modem_sync_q[g*4 +: 4] ^ modem_prev_q[g*4 +: 4];
		end
	endgenerate

	// the summary select overrides every address, so it masks both side effects
	// limitation: that select is taken as a same-clock signal, not synchronised
	assign msr_read = rd_strobe && fifo_status_select_n && page != `PAGE_ENHANCED
		&& reg_addr == `ADDR_MODEM_STATUS;
	assign hold_read = rd_strobe && fifo_status_select_n && page == `PAGE_BASE
		&& reg_addr == `ADDR_HOLDING;
	assign msr_value = {~modem_sync_q[chan_sel*4 +: 4], modem_delta_q[chan_sel]};

	// byte of one channel out of a packed four-channel word
	function [7:0] byte_of;
		input [31:0] word;
		input [1:0] ch;
		begin
			byte_of = word[ch*8 +: 8];
		end
	endfunction

	// page map by line control value:
	//   key value       -> enhanced page (features, flow characters)
	//   divisor bit set -> divisor page (low, high, fraction)
	//   anything else   -> base page (holding, enables, status)
	// the key has the divisor bit set too, so it must be tested first
	// page chosen by the line control value; key wins over divisor bit
	function [1:0] page_of;
		input [7:0] lc;
		begin
			if (lc == `ENHANCED_KEY)
				page_of = `PAGE_ENHANCED;
			else if (lc[`LC_DIVISOR_BIT])
				page_of = `PAGE_DIVISOR;
			else
				page_of = `PAGE_BASE;
		end
	endfunction

	// hide extended bits while they are locked
	// masks rather than clears storage, so relocking keeps the written value
	function [7:0] gate_ext;
		input [7:0] value;
		input [7:0] ext_mask;
		input unlocked;
		begin
			gate_ext = unlocked ? value : (value & ~ext_mask);
		end
	endfunction

	// decode of the selected channel, shared by read and write paths
	always @* begin
		page = page_of(line_control_q[chan_sel]);
		ext = unlocked[chan_sel];
	end

	// reads are combinational here and registered into rd_data on the strobe
	// read mux; write-only registers yield their address partner
	always @* begin
		rd_d = 8'h00;
		if (!fifo_status_select_n) begin
			rd_d = {rx_ready_n, tx_ready_n};
		end else begin
			case (page)
			`PAGE_DIVISOR: begin
				case (reg_addr)
				// divisor page: line and modem control, modem status and scratch stay reachable
				`ADDR_HOLDING: rd_d = div_low_q[chan_sel];
				`ADDR_ENABLE: rd_d = div_high_q[chan_sel];
				`ADDR_STATUS_CTRL: rd_d = ext ? (div_frac_q[chan_sel] & `DF_STORED_MASK) : 8'h00;
				`ADDR_LINE_CONTROL: rd_d = line_control_q[chan_sel];
				`ADDR_MODEM_CONTROL: rd_d = gate_ext(modem_control_q[chan_sel], `MC_EXT_MASK, ext);
				`ADDR_MODEM_STATUS: rd_d = msr_value;
				`ADDR_SCRATCH: rd_d = scratch_q[chan_sel];
				default: rd_d = 8'h00;
				endcase
			end
			`PAGE_ENHANCED: begin
				case (reg_addr)
				// enhanced page: features word and the flow characters
				`ADDR_STATUS_CTRL: rd_d = enhanced_q[chan_sel];
				`ADDR_LINE_CONTROL: rd_d = line_control_q[chan_sel];
				`ADDR_MODEM_CONTROL: rd_d = resume_one_q[chan_sel];
				`ADDR_LINE_STATUS: rd_d = resume_two_q[chan_sel];
				`ADDR_MODEM_STATUS: rd_d = stop_one_q[chan_sel];
				`ADDR_SCRATCH: rd_d = stop_two_q[chan_sel];
				default: rd_d = 8'h00;
				endcase
			end
			default: begin
				case (reg_addr)
				// base page: live status inputs are not latched here
				`ADDR_HOLDING: rd_d = byte_of(rx_char_all, chan_sel);
				`ADDR_ENABLE: rd_d = gate_ext(int_enable_q[chan_sel], `IE_EXT_MASK, ext);
				`ADDR_STATUS_CTRL: begin
					// fifo control is write-only, so its partner answers
					rd_d = gate_ext({2'h0, int_source_all[chan_sel*6 +: 6]}, `IS_EXT_MASK, ext);
					rd_d[7:6] = {2{fifo_control_q[chan_sel][`FC_ENABLE_BIT]}};
				end
				`ADDR_LINE_CONTROL: rd_d = line_control_q[chan_sel];
				`ADDR_MODEM_CONTROL: rd_d = gate_ext(modem_control_q[chan_sel], `MC_EXT_MASK, ext);
				`ADDR_LINE_STATUS: rd_d = byte_of(line_status_all, chan_sel);
				`ADDR_MODEM_STATUS: rd_d = msr_value;
				`ADDR_SCRATCH: rd_d = scratch_q[chan_sel];
				default: rd_d = 8'h00;
				endcase
			end
			endcase
		end
	end

	// modem pins pass two flops before any logic looks at them
	// reset loads ones: pins idle high, so no false change follows reset
	always @(posedge ref_clk) begin
		if (reset) begin
			modem_meta_q <= 16'hffff;
			modem_sync_q <= 16'hffff;
			modem_prev_q <= 16'hffff;
		end else begin
			modem_meta_q <= modem_pins_n_all;
			modem_sync_q <= modem_meta_q;
			modem_prev_q <= modem_sync_q;
		end
	end

	// register writes, read side effects and change flags
	always @(posedge ref_clk) begin
		if (reset) begin
			for (i = 0; i < `CHAN_COUNT; i = i + 1) begin
				// configuration words
				line_control_q[i] <= `REG_RESET;
				int_enable_q[i] <= `REG_RESET;
				fifo_control_q[i] <= `REG_RESET;
				modem_control_q[i] <= `REG_RESET;
				scratch_q[i] <= `REG_RESET;
				div_low_q[i] <= `REG_RESET;
				div_high_q[i] <= `REG_RESET;
				div_frac_q[i] <= `REG_RESET;
				enhanced_q[i] <= `REG_RESET;
				// flow characters
				resume_one_q[i] <= `FLOW_CHAR_RESET;
				resume_two_q[i] <= `FLOW_CHAR_RESET;
				stop_one_q[i] <= `FLOW_CHAR_RESET;
				stop_two_q[i] <= `FLOW_CHAR_RESET;
				// change flags
				modem_delta_q[i] <= 4'h0;
			end
			rd_data <= 8'h00;
			rx_char_pop <= 4'h0;
			tx_char_load <= 4'h0;
			tx_char_data <= 8'h00;
			rx_fifo_reset <= 4'h0;
			tx_fifo_reset <= 4'h0;
		end else begin
			rx_char_pop <= 4'h0;
			tx_char_load <= 4'h0;
			rx_fifo_reset <= 4'h0;
			tx_fifo_reset <= 4'h0;
			if (rd_strobe)
				rd_data <= rd_d;
			// change flags: a pin change in the reading cycle survives the clear
			for (i = 0; i < `CHAN_COUNT; i = i + 1) begin
				if (msr_read && chan_sel == i)
					modem_delta_q[i] <= modem_change[i*4 +: 4];
				else
					modem_delta_q[i] <= modem_delta_q[i] | modem_change[i*4 +: 4];
			end
			// reading the holding register takes the oldest character
			if (hold_read)
				rx_char_pop[chan_sel] <= 1'b1;
			if (wr_strobe) begin
				case (page)
				`PAGE_DIVISOR: begin
					case (reg_addr)
					// divisor page
					`ADDR_HOLDING: div_low_q[chan_sel] <= wr_data;
					`ADDR_ENABLE: div_high_q[chan_sel] <= wr_data;
					`ADDR_STATUS_CTRL: begin
						// fraction is locked away until extended bits unlock
						if (ext)
							div_frac_q[chan_sel] <= wr_data & `DF_STORED_MASK;
					end
					`ADDR_LINE_CONTROL: line_control_q[chan_sel] <= wr_data;
					`ADDR_MODEM_CONTROL: modem_control_q[chan_sel] <= wr_data;
					`ADDR_SCRATCH: scratch_q[chan_sel] <= wr_data;
					default: ;
					endcase
				end
				`PAGE_ENHANCED: begin
					case (reg_addr)
					// enhanced page
					`ADDR_STATUS_CTRL: enhanced_q[chan_sel] <= wr_data;
					`ADDR_LINE_CONTROL: line_control_q[chan_sel] <= wr_data;
					`ADDR_MODEM_CONTROL: resume_one_q[chan_sel] <= wr_data;
					`ADDR_LINE_STATUS: resume_two_q[chan_sel] <= wr_data;
					`ADDR_MODEM_STATUS: stop_one_q[chan_sel] <= wr_data;
					`ADDR_SCRATCH: stop_two_q[chan_sel] <= wr_data;
					default: ;
					endcase
				end
				default: begin
					case (reg_addr)
					// base page
					`ADDR_HOLDING: begin
						tx_char_data <= wr_data;
						tx_char_load[chan_sel] <= 1'b1;
					end
					`ADDR_ENABLE: int_enable_q[chan_sel] <= wr_data;
					`ADDR_STATUS_CTRL: begin
						// fifo resets self-clear, so only the lasting fields are kept
						fifo_control_q[chan_sel] <= wr_data & `FC_STORED_MASK;
						rx_fifo_reset[chan_sel] <= wr_data[`FC_RX_RESET_BIT];
						tx_fifo_reset[chan_sel] <= wr_data[`FC_TX_RESET_BIT];
					end
					`ADDR_LINE_CONTROL: line_control_q[chan_sel] <= wr_data;
					`ADDR_MODEM_CONTROL: modem_control_q[chan_sel] <= wr_data;
					`ADDR_SCRATCH: scratch_q[chan_sel] <= wr_data;
					// line and modem status are read-only: writes dropped
					default: ;
					endcase
				end
				endcase
			end
		end
	end

	// a write shows here one edge after storage takes it
	// configuration outputs, one cycle behind storage, extended bits gated
	always @(posedge ref_clk) begin
		if (reset) begin
			// control words
			line_control_all <= 32'h0;
			int_enable_all <= 32'h0;
			fifo_control_all <= 32'h0;
			modem_control_all <= 32'h0;
			enhanced_all <= 32'h0;
			// divisor
			divisor_low_all <= 32'h0;
			divisor_high_all <= 32'h0;
			divisor_frac_all <= 32'h0;
			// flow characters
			resume_char_one_all <= 32'h0;
			resume_char_two_all <= 32'h0;
			stop_char_one_all <= 32'h0;
			stop_char_two_all <= 32'h0;
		end else begin
			for (i = 0; i < `CHAN_COUNT; i = i + 1) begin
				line_control_all[i*8 +: 8] <= line_control_q[i];
				int_enable_all[i*8 +: 8] <= gate_ext(int_enable_q[i], `IE_EXT_MASK,
					enhanced_q[i][`EF_EXTEND_BIT]);
				fifo_control_all[i*8 +: 8] <= gate_ext(fifo_control_q[i], `FC_EXT_MASK,
					enhanced_q[i][`EF_EXTEND_BIT]);
				modem_control_all[i*8 +: 8] <= gate_ext(modem_control_q[i], `MC_EXT_MASK,
					enhanced_q[i][`EF_EXTEND_BIT]);
				// plain copies; only the fraction depends on the unlock bit
				enhanced_all[i*8 +: 8] <= enhanced_q[i];
				divisor_low_all[i*8 +: 8] <= div_low_q[i];
				divisor_high_all[i*8 +: 8] <= div_high_q[i];
				divisor_frac_all[i*8 +: 8] <= unlocked[i] ? div_frac_q[i] : 8'h00;
				resume_char_one_all[i*8 +: 8] <= resume_one_q[i];
				resume_char_two_all[i*8 +: 8] <= resume_two_q[i];
				stop_char_one_all[i*8 +: 8] <= stop_one_q[i];
				stop_char_two_all[i*8 +: 8] <= stop_two_q[i];
			end
		end
	end

endmodule

// ===== tb/quad_uart_regs_sva.sv
/*
 * port assertions for the four-channel register bank.
 * assumes: bound to quad_uart_regs; one clock, synchronous reset.
 */
`timescale 1ns/10ps
module quad_uart_regs_sva (
	input wire ref_clk,
	input wire reset,
	input wire [1:0] chan_sel,
	input wire [2:0] reg_addr,
	input wire rd_strobe,
	input wire wr_strobe,
	input wire [7:0] wr_data,
	input wire fifo_status_select_n,
	input wire [3:0] tx_ready_n,
	input wire [3:0] rx_ready_n,
	input wire [7:0] rd_data,
	input wire [3:0] rx_char_pop,
	input wire [3:0] tx_char_load,
	input wire [7:0] tx_char_data,
	input wire [3:0] rx_fifo_reset,
	input wire [3:0] tx_fifo_reset,
	input wire [31:0] line_control_all,
	input wire [31:0] int_enable_all,
	input wire [31:0] fifo_control_all,
	input wire [31:0] modem_control_all,
	input wire [31:0] enhanced_all,
	input wire [31:0] divisor_frac_all
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// page outputs lag one cycle, so a write just before the read is left out
	sequence hold_read;
		rd_strobe && fifo_status_select_n && reg_addr == 3'h0 && !line_control_all[{chan_sel, 3'h7}] && !$past(wr_strobe);
	endsequence
	sequence lc_write;
		wr_strobe && reg_addr == 3'h3 && chan_sel == 2'h0;
	endsequence
	pop_on_read_a: assert property (hold_read |=> rx_char_pop == (4'h1 << $past(chan_sel)))
		else $error("holding read gave no pop");
	pop_cause_a: assert property (rx_char_pop != 4'h0 |-> $past(rd_strobe && fifo_status_select_n && reg_addr == 3'h0))
		else $error("pop without holding read");
	fifo_summary_a: assert property (rd_strobe && !fifo_status_select_n |=> rd_data == $past({rx_ready_n, tx_ready_n}) && rx_char_pop == 4'h0)
		else $error("fifo summary read wrong");
	tx_load_a: assert property (tx_char_load != 4'h0 |-> $past(wr_strobe && reg_addr == 3'h0) && tx_char_data == $past(wr_data))
		else $error("transmit load wrong");
	fifo_reset_a: assert property (rx_fifo_reset != 4'h0 |-> $past(wr_strobe && reg_addr == 3'h2 && wr_data[1]))
		else $error("receive fifo reset without cause");
	tx_reset_a: assert property (tx_fifo_reset != 4'h0 |-> $past(wr_strobe && reg_addr == 3'h2 && wr_data[2]))
		else $error("transmit fifo reset without cause");
	ext_gated_a: assert property (!enhanced_all[4] |-> int_enable_all[7:4] == 4'h0 && fifo_control_all[5:4] == 2'h0 && modem_control_all[7:5] == 3'h0 && divisor_frac_all[7:0] == 8'h00)
		else $error("extended bits live while locked");
	reserved_zero_a: assert property ((fifo_control_all & 32'h06060606) == 32'h0 && (divisor_frac_all & 32'hc0c0c0c0) == 32'h0)
		else $error("reserved bits not zero");
	lc_update_a: assert property (lc_write |=> ##1 line_control_all[7:0] == $past(wr_data, 2))
		else $error("line control output not updated");
endmodule
bind quad_uart_regs quad_uart_regs_sva chk (.*);

// ===== tb/host_bus_model.sv
/*
 * host processor model: one-cycle read and write strobes.
 * assumes: caller waits on no handshake; answers come one cycle later.
 */
`timescale 1ns/10ps
module host_bus_model (
	input wire ref_clk,
	output reg [1:0] chan_sel,
	output reg [2:0] reg_addr,
	output reg rd_strobe,
	output reg wr_strobe,
	output reg [7:0] wr_data,
	output reg fifo_status_select_n
);
	// idle bus at time zero
	initial begin
		chan_sel = 2'h0;
		reg_addr = 3'h0;
		rd_strobe = 1'b0;
		wr_strobe = 1'b0;
		wr_data = 8'h00;
		fifo_status_select_n = 1'b1;
	end
	// strobe drops on the taking edge so accesses run back to back
	task wr(input [1:0] ch, input [2:0] a, input [7:0] d);
		begin
			@(negedge ref_clk);
			chan_sel = ch;
			reg_addr = a;
			wr_data = d;
			fifo_status_select_n = 1'b1;
			wr_strobe = 1'b1;
			@(posedge ref_clk);
			wr_strobe <= 1'b0;
			wr_data <= ~d; // released data must not look held
		end
	endtask
	// fsel low asks for the fifo ready summary
	task rd(input [1:0] ch, input [2:0] a, input fsel);
		begin
			@(negedge ref_clk);
			chan_sel = ch;
			reg_addr = a;
			fifo_status_select_n = fsel;
			rd_strobe = 1'b1;
			@(posedge ref_clk);
			rd_strobe <= 1'b0;
		end
	endtask
endmodule

// ===== tb/test_quad_uart_regs.sv
/*
 * self-checking bench for the register bank: reads are noted in a queue
 * and matched by a monitor. assumes: host model drives the bus.
 */
`timescale 1ns/10ps
module test_quad_uart_regs;
	reg ref_clk;
	reg reset;
	wire [1:0] chan_sel;
	wire [2:0] reg_addr;
	wire rd_strobe, wr_strobe, fifo_status_select_n;
	wire [7:0] wr_data, rd_data, tx_char_data;
	wire [31:0] fifo_control_all, modem_control_all, stop_char_two_all, divisor_low_all, divisor_high_all;
	reg [31:0] rx_char_all, line_status_all;
	reg [23:0] int_source_all;
	reg [15:0] modem_pins_n_all;
	reg [3:0] tx_ready_n, rx_ready_n;
	reg [7:0] exp_q[$];
	reg [7:0] r[0:3];
	reg rd_seen;
	integer bad_count, checks, i;

	host_bus_model host (.ref_clk(ref_clk), .chan_sel(chan_sel), .reg_addr(reg_addr), .rd_strobe(rd_strobe),
		.wr_strobe(wr_strobe), .wr_data(wr_data), .fifo_status_select_n(fifo_status_select_n));
	quad_uart_regs dut (.ref_clk(ref_clk), .reset(reset), .chan_sel(chan_sel), .reg_addr(reg_addr),
		.rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data), .fifo_status_select_n(fifo_status_select_n),
		.rx_char_all(rx_char_all), .line_status_all(line_status_all), .int_source_all(int_source_all),
		.modem_pins_n_all(modem_pins_n_all), .tx_ready_n(tx_ready_n), .rx_ready_n(rx_ready_n), .rd_data(rd_data),
		.rx_char_pop(), .tx_char_load(), .tx_char_data(tx_char_data), .rx_fifo_reset(), .tx_fifo_reset(),
		.line_control_all(), .int_enable_all(), .fifo_control_all(fifo_control_all),
		.modem_control_all(modem_control_all), .enhanced_all(), .divisor_low_all(divisor_low_all),
		.divisor_high_all(divisor_high_all),
		.divisor_frac_all(), .resume_char_one_all(), .resume_char_two_all(), .stop_char_one_all(),
		.stop_char_two_all(stop_char_two_all));

	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task chk8(input [8*16-1:0] name, input [7:0] e, input [7:0] g);
		begin
			checks = checks + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0s expected %h seen %h", name, e, g);
			end
		end
	endtask
	task exp_rd(input [1:0] ch, input [2:0] a, input fsel, input [7:0] e);
		begin
			exp_q.push_back(e);
			host.rd(ch, a, fsel);
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", checks, bad_count);
			if (bad_count == 0 && checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	// read answers stand one cycle, so they are compared mid-cycle
	always @(posedge ref_clk) rd_seen <= rd_strobe && !reset;
	always @(negedge ref_clk) begin
		if (rd_seen)
			chk8("rd_data", exp_q.pop_front(), rd_data);
	end
	// a hung run still reaches the verdict
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count = bad_count + 1;
		end_sim;
	end
	initial begin
		bad_count = 0;
		checks = 0;
		reset = 1'b1;
		rd_seen = 1'b0;
		rx_char_all = 32'h0;
		line_status_all = 32'h0;
		int_source_all = 24'h0;
		modem_pins_n_all = 16'hffff;
		tx_ready_n = 4'hf;
		rx_ready_n = 4'hf;
		void'($urandom(32'h3042fa3b));
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		host.wr(2'h0, 3'h3, 8'hbf);
		for (i = 4; i < 8; i = i + 1) exp_rd(2'h0, i[2:0], 1'b1, 8'h00);
		for (i = 4; i < 8; i = i + 1) begin
			r[i[1:0]] = 8'($urandom);
			host.wr(2'h0, i[2:0], r[i[1:0]]);
		end
		host.wr(2'h0, 3'h2, 8'h10);
		for (i = 4; i < 8; i = i + 1) exp_rd(2'h0, i[2:0], 1'b1, r[i[1:0]]);
		exp_rd(2'h0, 3'h2, 1'b1, 8'h10);
		exp_rd(2'h0, 3'h0, 1'b1, 8'h00);
		chk8("stop_char_two", r[3], stop_char_two_all[7:0]);
		$display("done enhanced page");
		host.wr(2'h0, 3'h3, 8'h80);
		host.wr(2'h0, 3'h0, 8'h5a);
		host.wr(2'h0, 3'h1, 8'ha5);
		host.wr(2'h0, 3'h2, 8'hff);
		host.wr(2'h1, 3'h3, 8'h80);
		host.wr(2'h1, 3'h2, 8'hff);
		exp_rd(2'h0, 3'h0, 1'b1, 8'h5a);
		exp_rd(2'h0, 3'h1, 1'b1, 8'ha5);
		exp_rd(2'h0, 3'h2, 1'b1, 8'h3f);
		exp_rd(2'h1, 3'h2, 1'b1, 8'h00);
		exp_rd(2'h0, 3'h3, 1'b1, 8'h80);
		chk8("divisor_low", 8'h5a, divisor_low_all[7:0]);
		chk8("divisor_high", 8'ha5, divisor_high_all[7:0]);
		$display("done divisor page");
		@(negedge ref_clk);
		int_source_all = 24'h00002a;
		host.wr(2'h0, 3'h3, 8'h00);
		host.wr(2'h0, 3'h4, 8'hff);
		host.wr(2'h0, 3'h1, 8'hff);
		host.wr(2'h0, 3'h2, 8'h37);
		exp_rd(2'h0, 3'h4, 1'b1, 8'hff);
		exp_rd(2'h0, 3'h1, 1'b1, 8'hff);
		exp_rd(2'h0, 3'h2, 1'b1, 8'hea);
		chk8("fifo_control", 8'h31, fifo_control_all[7:0]);
		chk8("modem_control", 8'hff, modem_control_all[7:0]);
		$display("done base page");
		@(negedge ref_clk);
		rx_char_all = $urandom;
		for (i = 0; i < 4; i = i + 1) begin
			r[i[1:0]] = 8'($urandom);
			host.wr(i[1:0], 3'h7, r[i[1:0]]);
		end
		host.wr(2'h1, 3'h3, 8'h00);
		host.wr(2'h1, 3'h1, 8'hff);
		host.wr(2'h1, 3'h4, 8'hff);
		exp_rd(2'h1, 3'h1, 1'b1, 8'h0f);
		exp_rd(2'h1, 3'h4, 1'b1, 8'h1f);
		for (i = 0; i < 4; i = i + 1) begin
			exp_rd(i[1:0], 3'h7, 1'b1, r[i[1:0]]);
			exp_rd(i[1:0], 3'h0, 1'b1, rx_char_all[8*i +: 8]);
		end
		host.wr(2'h2, 3'h0, 8'hc3);
		@(negedge ref_clk);
		chk8("tx_char_data", 8'hc3, tx_char_data);
		$display("done channels");
		line_status_all = $urandom;
		modem_pins_n_all = 16'hfffa;
		host.wr(2'h0, 3'h5, 8'h00);
		host.wr(2'h0, 3'h6, 8'h00);
		repeat (4) @(posedge ref_clk);
		exp_rd(2'h0, 3'h5, 1'b1, line_status_all[7:0]);
		exp_rd(2'h0, 3'h6, 1'b1, 8'h55);
		exp_rd(2'h0, 3'h6, 1'b1, 8'h50);
		$display("done status registers");
		@(negedge ref_clk);
		{rx_ready_n, tx_ready_n} = 8'($urandom);
		for (i = 0; i < 8; i = i + 1) exp_rd(2'h3, i[2:0], 1'b0, {rx_ready_n, tx_ready_n});
		repeat (2) @(negedge ref_clk);
		$display("done fifo summary");
		end_sim;
	end
endmodule
